// *** rtl/pcsr_ctrl.sv ***
/*
  Register bank for clock output, dimming select, sink current and
  regulator enables. core_clk stands for the crystal oscillator;
  clockOutputPin toggles each oscillator half period scaled by the divider.
  Comparator inputs come from analog and are synchronised here.
  Assumes a same-clock serial slave ahead of the strobe port and a
  lockout detector that pulses uvloRelease for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pcsr_ctrl
  import pcsr_pkg::*;
(
  input  wire logic       core_clk,      // Oscillator-domain clock
  input  wire logic       sys_rst,       // Async reset, high
  input  wire logic       uvloRelease,   // Pulse: lockout released
  input  wire logic       wrEn,          // Register write strobe
  input  wire logic       rdEn,          // Register read strobe
  input  wire logic [7:0] regAddr,       // Register address
  input  wire logic [7:0] wrData,        // Write data
  output logic      [7:0] rdData,        // Read data, registered
  input  wire logic       aboveHiCmp,    // Analog: A above 95%
  input  wire logic       belowLoCmp,    // Analog: A below 90%
  input  wire logic       aboveHiCmpB,   // Analog: B above 95%
  input  wire logic       belowLoCmpB,   // Analog: B below 90%
  output logic            regulatorAOn,  // Regulator A enable
  output logic            regulatorBOn,  // Regulator B enable
  output logic      [1:0] dimmingFreqSel,// Dimming frequency select
  output logic            oscForceOn,    // Crystal oscillator force-on
  output logic            clockOutputPin,// Divided clock out
  output logic      [4:0] ledSinkCurrent // Sink current setting
);
  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  logic [1:0] dimFreq_q;    // Dimming select
  logic       clkEn_q;      // Clock output enable
  logic [1:0] clkDiv_q;     // Clock divider select
  logic       aOn_q;        // Regulator A enable
  logic       bOn_q;        // Regulator B enable
  logic [2:0] divCnt_q;     // Divider counter
  logic       clock_output_pin_q;     // Clock output flop
  // Two-flop synchronisers; comparators are asynchronous to core_clk
  logic [1:0] aHiS_q;       // A above rising threshold
  logic [1:0] aLoS_q;       // A below falling threshold
  logic [1:0] bHiS_q;       // B above rising threshold
  logic [1:0] bLoS_q;       // B below falling threshold
  logic       aOk_q;        // A power-good, hysteretic
  logic       bOk_q;        // B power-good, hysteretic

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  wire wrOsc  = wrEn && (regAddr == OFS_OSC_DIM);
  wire wrReg  = wrEn && (regAddr == OFS_REG_CTRL);
  // Clock output runs only with the enable bit and regulator A on
  wire clkRun = clkEn_q && aOn_q; // [R04]
  // Terminal count: 2^div / 2 - 1 half-cycles; divide-by-1 passes clk
  wire [2:0] divTop = (clkDiv_q == 2'h3) ? HALF_DIV8 :
                      (clkDiv_q == 2'h2) ? HALF_DIV4 :
                      (clkDiv_q == 2'h1) ? HALF_DIV2 : HALF_DIV1; // [R06]
  // Compare with >= so a smaller divider written mid-count wraps at once
  wire divWrap = (divCnt_q >= divTop);

  // Register writes; lockout release reloads defaults
  // Release outranks a write landing in the same cycle, so the host
  // must rewrite anything it set before the lockout
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dimFreq_q <= RST_DIM_FREQ;  // [R01]
      clkEn_q   <= RST_CLK_EN;
      clkDiv_q  <= RST_CLK_DIV;   // [R06]
      aOn_q     <= RST_REG_ON;    // [R12]
      bOn_q     <= RST_REG_ON;    // [R11]
    end else if (uvloRelease) begin // [R13]
      // Reload mirrors the reset values above
      dimFreq_q <= RST_DIM_FREQ;
      clkEn_q   <= RST_CLK_EN;
      clkDiv_q  <= RST_CLK_DIV;
      aOn_q     <= RST_REG_ON;
      bOn_q     <= RST_REG_ON;
    end else begin
      // Only the mapped fields are taken from the write byte
      if (wrOsc) begin // Spare bits dropped [R13]
        dimFreq_q <= wrData[POS_DIM_FREQ +: 2]; // [R01]
        clkEn_q   <= wrData[POS_CLK_EN];
        clkDiv_q  <= wrData[POS_CLK_DIV +: 2];
      end
      // Bits 5:4 of this byte are live status and are dropped
      if (wrReg) begin // Status bits not writable [R10]
        aOn_q <= wrData[POS_A_ON]; // [R12]
        bOn_q <= wrData[POS_B_ON]; // [R11]
      end
    end
  end

  // -----------------------------------------------------------------
  // Clock output divider
  // -----------------------------------------------------------------
  // Divide-by-1 cannot be made from flops at core rate; gate instead
  // The count restarts at zero whenever the output stops, so the first
  // edge after enabling comes a full half period later
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_q <= 3'h0;
      clock_output_pin_q <= 1'b0;
    end else if (!clkRun) begin // [R02]
      divCnt_q <= 3'h0;
      clock_output_pin_q <= 1'b0;
    end else if (divWrap) begin // [R03]
      divCnt_q <= 3'h0;
      clock_output_pin_q <= ~clock_output_pin_q;
    end else begin
      divCnt_q <= divCnt_q + 3'h1;
    end
  end
  // Hazard: the gated path may give a short first pulse when clkRun
  // changes while core_clk is high; the load must tolerate it
  // Divide-by-1 passes the oscillator itself, gated low when off
  assign clockOutputPin = (clkDiv_q == 2'h0) ? (clkRun & core_clk) : clock_output_pin_q; // [R03]

  // -----------------------------------------------------------------
  // Power-good hysteresis from synchronised comparators
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aHiS_q <= 2'h0;
      aLoS_q <= 2'h0;
      bHiS_q <= 2'h0;
      bLoS_q <= 2'h0;
      aOk_q  <= 1'b0;
      bOk_q  <= 1'b0;
    end else begin
      // Shift comparator levels through two flops
      aHiS_q <= {aHiS_q[0], aboveHiCmp};
      aLoS_q <= {aLoS_q[0], belowLoCmp};
      bHiS_q <= {bHiS_q[0], aboveHiCmpB};
      bLoS_q <= {bLoS_q[0], belowLoCmpB};
      // Clear wins over set: a disabled or collapsing rail is never good
      // Set above 95%, clear below 90%, or when disabled [R08] [R09]
      if (!aOn_q || aLoS_q[1]) aOk_q <= 1'b0;
      else if (aHiS_q[1])      aOk_q <= 1'b1;
      if (!bOn_q || bLoS_q[1]) bOk_q <= 1'b0;
      else if (bHiS_q[1])      bOk_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  // Spare bits read zero; status is masked by the enable
  wire [7:0] rdOsc  = {3'h0, dimFreq_q, clkEn_q, clkDiv_q};
  wire [7:0] rdSink = {3'h0, RST_SINK}; // [R07]
  wire [7:0] rdReg  = {2'h0, bOk_q & bOn_q, aOk_q & aOn_q, 2'h0, bOn_q, aOn_q}; // [R10] [R09]
  // Unmapped addresses fall through to zero
  wire [7:0] rdMux  = (regAddr == OFS_OSC_DIM) ? rdOsc : (regAddr == OFS_SINK) ? rdSink :
                      (regAddr == OFS_REG_CTRL) ? rdReg : 8'h00;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    // Read data is registered and holds until the next read strobe
    if (sys_rst) rdData <= 8'h00;
    else if (rdEn) rdData <= rdMux;
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign regulatorAOn   = aOn_q;
  assign regulatorBOn   = bOn_q;
  assign dimmingFreqSel = dimFreq_q;
  assign oscForceOn     = clkEn_q; // [R05]
  // Sink setting is fixed; host writes cannot reach it
  assign ledSinkCurrent = RST_SINK; // [R07]

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  // Clock output gating and oscillator force
  AST_CLK_LOW: assert property (@(posedge core_clk) disable iff (sys_rst) // [R02]
    !clkEn_q |=> !clock_output_pin_q) else $error("clock out toggled while disabled");
  AST_NEED_A: assert property (@(posedge core_clk) disable iff (sys_rst) // [R04]
    !aOn_q |=> !clock_output_pin_q) else $error("clock out ran without regulator A");
  AST_OSC_ON: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
    wrOsc && !uvloRelease && wrData[POS_CLK_EN] |=> oscForceOn) else $error("oscillator not forced");
  // Divider periods
  AST_DIV8: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    clkRun && clkDiv_q == 2'h3 && $rose(clock_output_pin_q) |-> ##4 (clock_output_pin_q == 1'b0 || !clkRun))
    else $error("divide by 8 period wrong");
  AST_DIV4: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    clkRun && clkDiv_q == 2'h2 && $rose(clock_output_pin_q) |-> ##2 (!clock_output_pin_q || !clkRun || clkDiv_q != 2'h2))
    else $error("divide by 4 period wrong");
  AST_DIV2: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
    clkRun && clkDiv_q == 2'h1 |=> clock_output_pin_q != $past(clock_output_pin_q)) else $error("divide by 2 missed a toggle");
  // Read path
  AST_SINK: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
    rdEn && regAddr == OFS_SINK |=> rdData == 8'h08) else $error("sink current read wrong");
  AST_SPARE: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
    rdEn |=> rdData[7:6] == 2'h0) else $error("spare read bits not zero");
  AST_UNMAP: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
    rdEn && regAddr != OFS_OSC_DIM && regAddr != OFS_SINK && regAddr != OFS_REG_CTRL |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  // Power-good
  AST_OK_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // [R09]
    !aOn_q |=> !aOk_q) else $error("power good set while disabled");
  AST_B_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // [R09]
    !bOn_q |=> !bOk_q) else $error("regulator B power good set while disabled");
  AST_HYST: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
    aOn_q && !aLoS_q[1] && aHiS_q[1] |=> aOk_q) else $error("power good failed to set");
  AST_OK_DROP: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
    aLoS_q[1] |=> !aOk_q) else $error("power good held below low threshold");
  AST_B_DROP: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
    bLoS_q[1] |=> !bOk_q) else $error("regulator B power good held below low threshold");
  // Enables, control writes and reload
  AST_OSC_WR: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
    wrOsc && !uvloRelease |=> dimFreq_q == $past(wrData[POS_DIM_FREQ +: 2])
      && clkDiv_q == $past(wrData[POS_CLK_DIV +: 2])) else $error("oscillator control write lost");
  AST_REG_EN: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    wrReg && !uvloRelease |=> aOn_q == $past(wrData[0]) && bOn_q == $past(wrData[1]))
    else $error("regulator enable write lost");
  AST_RELOAD: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
    uvloRelease |=> dimFreq_q == RST_DIM_FREQ && !clkEn_q && !aOn_q) else $error("reload failed");
  COV_CLK_RUN: cover property (@(posedge core_clk) clkRun && $rose(clock_output_pin_q));
  COV_PGOOD:   cover property (@(posedge core_clk) $rose(aOk_q));
  COV_RELOAD:  cover property (@(posedge core_clk) uvloRelease && aOn_q);
  COV_DIV1:    cover property (@(posedge core_clk) clkRun && clkDiv_q == 2'h0);
  COV_BAND:    cover property (@(posedge core_clk) aOk_q && !aHiS_q[1] && !aLoS_q[1]);
endmodule // pcsr_ctrl
`default_nettype wire

// *** rtl/pcsr_pkg.sv ***
/*
  Constants for the oscillator, sink-current and regulator control bank.
  Assumes an upstream two-wire serial slave that presents byte-wide
  register writes and reads on a simple same-clock strobe interface.
*/
// How it works
// R01: Two-bit dimming frequency select, resets to 11
// R02: Clock output held low when disabled
// R03: Enabled clock output forces oscillator, toggles divided
// R04: Clock output runs only with regulator A on
// R05: Enable bit starts oscillator regardless of regulator
// R06: Divider field selects 1,2,4,8; resets 00
// R07: Sink current read-only, factory 01000
// R08: Power-good asserts above 95%, drops below 90%
// R09: Power-good reads 0 when disabled or low
// R10: Power-good bits at 5,4, live, read-only
// R11: Bit 1 enables regulator B, resets 0
// R12: Bit 0 enables regulator A, resets 0
// R13: Defaults reload on lockout release; spares read zero
package pcsr_pkg;
  // -----------------------------------------------------------------
  // Register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_OSC_DIM   = 8'h03;
  localparam logic [7:0] OFS_SINK      = 8'h04;
  localparam logic [7:0] OFS_REG_CTRL  = 8'h05;
  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int POS_DIM_FREQ  = 3;
  localparam int POS_CLK_EN    = 2;
  localparam int POS_CLK_DIV   = 0;
  localparam int POS_B_OK      = 5;
  localparam int POS_A_OK      = 4;
  localparam int POS_B_ON      = 1;
  localparam int POS_A_ON      = 0;
  // -----------------------------------------------------------------
  // Reset / factory values
  // -----------------------------------------------------------------
  localparam logic [1:0] RST_DIM_FREQ  = 2'h3;
  localparam logic       RST_CLK_EN    = 1'b0;
  localparam logic [1:0] RST_CLK_DIV   = 2'h0;
  localparam logic       RST_REG_ON    = 1'b0;
  localparam logic [4:0] RST_SINK      = 5'h08;
  // Oscillator half-period counts for divide by 1,2,4,8
  localparam logic [2:0] HALF_DIV1     = 3'h0;
  localparam logic [2:0] HALF_DIV2     = 3'h0;
  localparam logic [2:0] HALF_DIV4     = 3'h1;
  localparam logic [2:0] HALF_DIV8     = 3'h3;
endpackage

// *** testbench/pcsr_ctrl_tb.sv ***
/* Self-checking bench for the control bank.
   Assumes the strobe register port and the comparator model. */
`timescale 1ns/1ps
`default_nettype none
module pcsr_ctrl_tb import pcsr_pkg::*; ;
  logic core_clk = 1'b0, sys_rst = 1'b1, uvloRelease = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
  logic sagA = 1'b0, dropA = 1'b0, hiA, loA, hiB, loB, aOn, bOn, oscOn, pin;
  logic [7:0] regAddr = 8'h00, wrData = 8'h00, rdData;
  logic [1:0] dimSel;
  logic [4:0] sinkCur;
  int err_count = 0, checked = 0, pinEdges = 0, i;
  pcsr_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .uvloRelease(uvloRelease),
    .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr), .wrData(wrData), .rdData(rdData),
    .aboveHiCmp(hiA), .belowLoCmp(loA), .aboveHiCmpB(hiB), .belowLoCmpB(loB),
    .regulatorAOn(aOn), .regulatorBOn(bOn), .dimmingFreqSel(dimSel),
    .oscForceOn(oscOn), .clockOutputPin(pin), .ledSinkCurrent(sinkCur));
  pcsr_reg_model model (.core_clk(core_clk), .enA(aOn), .enB(bOn), .sagA(sagA),
    .dropA(dropA), .hiA(hiA), .loA(loA), .hiB(hiB), .loB(loB));
  initial forever #5 core_clk = ~core_clk;
  always @(posedge pin) pinEdges++; // Counts rising output edges, gated clock too
  // ----
  // Compares and bus cycles
  // ----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkCnt(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("CHECK FAILED at %0t: %0d edges", $time, got);
    end
  endtask
  // Write held one edge; #1 lets the register update land
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wrEn <= 1'b1; regAddr <= a; wrData <= d;
    @(posedge core_clk);
    wrEn <= 1'b0;
    #1;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rdEn <= 1'b1; regAddr <= a;
    @(posedge core_clk);
    rdEn <= 1'b0;
    #1 chk8(rdData, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic fieldWrites;
    rdChk(OFS_OSC_DIM, 8'h18);
    rdChk(OFS_REG_CTRL, 8'h00);
    rdChk(8'h00, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(OFS_OSC_DIM, 8'(i << 3) | 8'he0); // Spares written high
      rdChk(OFS_OSC_DIM, 8'(i << 3));
      chk8({6'h0, dimSel}, 8'(i));
    end
    wr(OFS_SINK, 8'hf7);
    rdChk(OFS_SINK, 8'h08);
    chk8({3'h0, sinkCur}, 8'h08);
  endtask
  task automatic clockOut;
    wr(OFS_OSC_DIM, 8'h04); // Enabled, regulator A still off
    pinEdges = 0;
    repeat (16) @(posedge core_clk);
    chk8({7'h0, oscOn}, 8'h01);
    chkCnt(pinEdges, 0, 0);
    wr(OFS_REG_CTRL, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(OFS_OSC_DIM, 8'h04 | 8'(i));
      repeat (4) @(posedge core_clk);
      pinEdges = 0;
      repeat (64) @(posedge core_clk);
      chkCnt(pinEdges, (64 >> i) - 1, (64 >> i) + 1);
    end
    wr(OFS_OSC_DIM, 8'h03);
    repeat (4) @(posedge core_clk);
    pinEdges = 0;
    repeat (32) @(posedge core_clk);
    chkCnt(pinEdges, 0, 0);
    chk8({6'h0, oscOn, pin}, 8'h00);
    wr(OFS_OSC_DIM, 8'h00); // Divide by 1, disabled, regulator A on
    pinEdges = 0;
    repeat (16) @(posedge core_clk);
    chkCnt(pinEdges, 0, 0);
  endtask
  task automatic powerGood;
    wr(OFS_REG_CTRL, 8'hff); // Status and spare bits must not take
    chk8({6'h0, bOn, aOn}, 8'h03);
    rdChk(OFS_REG_CTRL, 8'h13);
    repeat (12) @(posedge core_clk);
    rdChk(OFS_REG_CTRL, 8'h33);
    @(posedge core_clk);
    sagA <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdChk(OFS_REG_CTRL, 8'h33);
    @(posedge core_clk);
    dropA <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdChk(OFS_REG_CTRL, 8'h23);
    @(posedge core_clk);
    sagA <= 1'b0;
    dropA <= 1'b0;
    repeat (12) @(posedge core_clk);
    wr(OFS_REG_CTRL, 8'h01);
    rdChk(OFS_REG_CTRL, 8'h11);
  endtask
  task automatic reload;
    wr(OFS_OSC_DIM, 8'h07);
    @(posedge core_clk);
    uvloRelease <= 1'b1;
    @(posedge core_clk);
    uvloRelease <= 1'b0;
    rdChk(OFS_OSC_DIM, 8'h18);
    rdChk(OFS_REG_CTRL, 8'h00);
  endtask
  task automatic summarize;
    $display("Mismatches %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: a bounded run, overrun counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    fieldWrites();
    clockOut();
    powerGood();
    reload();
    summarize();
  end
endmodule // pcsr_ctrl_tb
`default_nettype wire

// *** testbench/pcsr_reg_model.sv ***
/* Regulator comparator model for the control bank bench.
   Assumes enables from the bank and fault levels from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pcsr_reg_model (
  input  wire logic core_clk,
  input  wire logic enA,
  input  wire logic enB,
  input  wire logic sagA,  // A between 90% and 95%
  input  wire logic dropA, // A below 90%
  output logic      hiA,
  output logic      loA,
  output logic      hiB,
  output logic      loB
);
  logic [3:0] rampA_q; // Soft start, four cycles
  logic [3:0] rampB_q;
  // Output rises slowly but collapses at once when disabled
  always_ff @(posedge core_clk) begin
    rampA_q <= enA ? {rampA_q[2:0], 1'b1} : 4'h0;
    rampB_q <= enB ? {rampB_q[2:0], 1'b1} : 4'h0;
  end
  assign hiA = rampA_q[3] && !sagA && !dropA;
  assign loA = !rampA_q[3] || dropA;
  assign hiB = rampB_q[3];
  assign loB = !rampB_q[3];
endmodule // pcsr_reg_model
`default_nettype wire
